// [adcc_pkg.sv]
// Constants, field layouts and carrier types for the converter control block.
// Assumes an APB master with 32-bit data; each 8-bit register sits in the low byte of one word.
// Function
// - High result register holds result bits nine down to two.
// - Low register bits one and zero hold result bits one and zero.
// - Input above upper reference saturates result to all ones, no overflow flag.
// - Input below lower reference gives zero in both result registers.
// - Three-bit selector picks input zero to four; readable and writable.
// - Setting converter-on starts conversions, repeated back to back while set.
// - Clearing converter-on switches the converter off and halts conversions.
// - Each finished conversion updates both result registers and sets done flag.
// - Done clears on high result read or control write, not low read.
// - Selector change mid-conversion aborts, clears done, restarts on new input.
// - Conversion clock is CPU/2, CPU, or CPU/4 from quarter-rate and rate bits.
// - Halt mode disables converter; results accurate only after stabilisation time.
// - Wait mode leaves conversions running normally.
// - Low register bits seven to four always read zero.
// - Reset clears the control register to zero.
package adcc_pkg;
    // Register indices; printed offsets are not word aligned, byte address is index times four
    localparam logic [7:0] ADCC_IDX_CTRL = 8'h36;
    localparam logic [7:0] ADCC_IDX_RESH = 8'h37;
    localparam logic [7:0] ADCC_IDX_RESL = 8'h38;
    localparam int ADCC_ADDR_W = 12;
    localparam logic [ADCC_ADDR_W-1:0] ADCC_ADDR_CTRL = {2'h0, ADCC_IDX_CTRL, 2'h0};
    localparam logic [ADCC_ADDR_W-1:0] ADCC_ADDR_RESH = {2'h0, ADCC_IDX_RESH, 2'h0};
    localparam logic [ADCC_ADDR_W-1:0] ADCC_ADDR_RESL = {2'h0, ADCC_IDX_RESL, 2'h0};
    // Control register fields, and the quarter-rate bit of the low register
    localparam int ADCC_CTRL_DONE = 7;
    localparam int ADCC_CTRL_RATE = 6;
    localparam int ADCC_CTRL_ON = 5;
    localparam int ADCC_SEL_HI = 2;
    localparam int ADCC_LOW_QUARTER = 3;
    localparam logic [7:0] ADCC_CTRL_RESET = 8'h00;
    // Result layout and highest input selector value
    localparam int ADCC_RES_W = 10;
    localparam logic [ADCC_RES_W-1:0] ADCC_RES_MAX = 10'h3FF;
    localparam logic [ADCC_RES_W-1:0] ADCC_RES_MIN = 10'h000;
    localparam logic [2:0] ADCC_SEL_MAX = 3'h4;
    // Conversion length: one sample cycle plus one step per result bit
    localparam int ADCC_SAMPLE_CYC = 1;
    localparam int ADCC_CONV_CYC = ADCC_SAMPLE_CYC + ADCC_RES_W;
    localparam logic [3:0] ADCC_CONV_LAST = 4'(ADCC_CONV_CYC - 1);
    // Clock divider end counts: full rate 0, half rate 1, quarter rate 3
    localparam logic [1:0] ADCC_DIV_FULL = 2'h0;
    localparam logic [1:0] ADCC_DIV_HALF = 2'h1;
    localparam logic [1:0] ADCC_DIV_QUARTER = 2'h3;
    // Stabilisation time after leaving halt, in ns, and its cycle count at 125 MHz
    localparam int ADCC_CLK_PERIOD_NS = 8;
    localparam int ADCC_STAB_NS = 1000;
    localparam int ADCC_STAB_CYC = (ADCC_STAB_NS + ADCC_CLK_PERIOD_NS - 1) / ADCC_CLK_PERIOD_NS;
    localparam logic [7:0] ADCC_STAB_LAST = 8'(ADCC_STAB_CYC - 1);

    typedef enum logic [1:0] {ADCC_OFF, ADCC_STAB, ADCC_CONV} adcc_state_e;

    // Analog front end: comparator result and range indications for the selected input
    typedef struct packed {
        logic cmp_high;
        logic over_range;
        logic under_range;
    } adcc_afe_in_s;

    typedef struct packed {
        logic powered;
        logic sample;
        logic [2:0] select;
        logic [ADCC_RES_W-1:0] trial;
    } adcc_afe_out_s;
endpackage : adcc_pkg

// [adcc_top.sv]
// Converter control: APB register file, conversion clock divider and successive approximation sequencer.
// Assumes the analog front end compares its sampled input with the trial code within one conversion-clock step.
`timescale 1ns/1ps
module adcc_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adcc_pkg::ADCC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power modes
    input wire logic halt_mode,
    input wire logic wait_mode,
    // Analog front end
    input wire adcc_pkg::adcc_afe_in_s afe_in,
    output adcc_pkg::adcc_afe_out_s afe_out,
    output logic results_accurate
);
    import adcc_pkg::*;

    logic [7:0] ctrl_r;
    logic quarter_r;
    logic [9:0] result_r;
    logic [9:0] trial_r;
    logic [3:0] step_r;
    logic [1:0] div_r;
    logic [7:0] stab_r;
    adcc_state_e state_r;
    logic acc_r;

    logic access, wr, rd, wr_ctrl, wr_low, rd_high, mapped;
    logic sel_change, tick, conv_done;
    logic [1:0] div_end;
    logic [9:0] final_code;
    logic [7:0] rd_byte;

    // Access decode; transfers finish in their first access cycle
    assign access = psel & penable;
    assign wr = access & pwrite & pstrb[0];
    assign rd = access & ~pwrite;
    assign mapped = (paddr == ADCC_ADDR_CTRL) | (paddr == ADCC_ADDR_RESH) | (paddr == ADCC_ADDR_RESL);
    assign wr_ctrl = wr & (paddr == ADCC_ADDR_CTRL);
    assign wr_low = wr & (paddr == ADCC_ADDR_RESL);
    assign rd_high = rd & (paddr == ADCC_ADDR_RESH);
    assign sel_change = wr_ctrl & (pwdata[ADCC_SEL_HI:0] != ctrl_r[ADCC_SEL_HI:0]);
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // Conversion clock: quarter rate overrides the rate bit
    always_comb begin
        if (quarter_r) begin
            div_end = ADCC_DIV_QUARTER;
        end else if (ctrl_r[ADCC_CTRL_RATE]) begin
            div_end = ADCC_DIV_FULL;
        end else begin
            div_end = ADCC_DIV_HALF;
        end
    end
    assign tick = (state_r == ADCC_CONV) && (div_r == div_end);

    // Divider counter, restarted whenever a conversion is restarted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 2'h0;
        end else if (state_r != ADCC_CONV || sel_change || tick) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end

    // Final code: saturate on range indications, otherwise last trial decision
    always_comb begin
        if (afe_in.over_range) begin
            final_code = ADCC_RES_MAX;
        end else if (afe_in.under_range) begin
            final_code = ADCC_RES_MIN;
        end else begin
            final_code = afe_in.cmp_high ? trial_r : (trial_r & ~10'h001);
        end
    end
    assign conv_done = tick && (step_r == ADCC_CONV_LAST) && !sel_change;

    // Sequencer state; wait mode is deliberately not an input to it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ADCC_OFF;
            stab_r <= 8'h00;
        end else if (!ctrl_r[ADCC_CTRL_ON] || halt_mode) begin
            state_r <= ADCC_OFF;
            stab_r <= 8'h00;
        end else begin
            case (state_r)
                ADCC_OFF: begin
                    state_r <= acc_r ? ADCC_CONV : ADCC_STAB;
                    stab_r <= 8'h00;
                end
                ADCC_STAB: begin
                    if (stab_r == ADCC_STAB_LAST) begin
                        state_r <= ADCC_CONV;
                    end
                    stab_r <= stab_r + 8'h01;
                end
                ADCC_CONV: state_r <= ADCC_CONV;
                default: state_r <= ADCC_OFF;
            endcase
        end
    end

    // Accuracy marker: lost in halt, regained after stabilisation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= 1'b0;
        end else if (halt_mode) begin
            acc_r <= 1'b0;
        end else if (state_r == ADCC_STAB && stab_r == ADCC_STAB_LAST) begin
            acc_r <= 1'b1;
        end
    end
    assign results_accurate = acc_r;

    // Successive approximation: step 0 samples, then one bit per step, MSB first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_r <= 4'h0;
            trial_r <= 10'h000;
        end else if (state_r != ADCC_CONV || sel_change) begin
            step_r <= 4'h0;
            trial_r <= 10'h000;
        end else if (tick) begin
            if (step_r == ADCC_CONV_LAST) begin
                step_r <= 4'h0;
                trial_r <= 10'h000;
            end else begin
                step_r <= step_r + 4'h1;
                if (step_r == 4'h0) begin
                    trial_r <= 10'h200;
                end else begin
                    trial_r <= (afe_in.cmp_high ? trial_r : (trial_r & ~(10'h200 >> (step_r - 4'h1))))
                               | (10'h200 >> step_r);
                end
            end
        end
    end

    // Result capture at end of conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= 10'h000;
        end else if (conv_done) begin
            result_r <= final_code;
        end
    end

    // Control register: software fields and the done flag, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= ADCC_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r[ADCC_CTRL_RATE:0] <= pwdata[ADCC_CTRL_RATE:0];
            end
            if (conv_done) begin
                ctrl_r[ADCC_CTRL_DONE] <= 1'b1;
            end else if (wr_ctrl || rd_high) begin
                ctrl_r[ADCC_CTRL_DONE] <= 1'b0;
            end
        end
    end

    // Quarter-rate bit in the low register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quarter_r <= 1'b0;
        end else if (wr_low) begin
            quarter_r <= pwdata[ADCC_LOW_QUARTER];
        end
    end

    // Read mux
    always_comb begin
        rd_byte = 8'h00;
        if (paddr == ADCC_ADDR_CTRL) begin
            rd_byte = ctrl_r;
        end else if (paddr == ADCC_ADDR_RESH) begin
            rd_byte = result_r[9:2];
        end else if (paddr == ADCC_ADDR_RESL) begin
            rd_byte = {4'h0, quarter_r, 1'b0, result_r[1:0]};
        end
    end

    // Read data register, loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // Front end drive
    always_comb begin
        afe_out.powered = (state_r != ADCC_OFF);
        afe_out.sample = (state_r == ADCC_CONV) && (step_r == 4'h0);
        afe_out.select = (ctrl_r[ADCC_SEL_HI:0] > ADCC_SEL_MAX) ? ADCC_SEL_MAX : ctrl_r[ADCC_SEL_HI:0];
        afe_out.trial = trial_r;
    end

    // Checks
    // Done flag follows a finished conversion
    AST_DONE_SET: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done |=> ctrl_r[ADCC_CTRL_DONE])
        else $error("done flag not set after conversion");

    // High result read clears done unless a new result lands
    AST_DONE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_high && !conv_done) |=> !ctrl_r[ADCC_CTRL_DONE])
        else $error("high read did not clear done");

    // Control write clears done unless a new result lands
    AST_DONE_WR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && !conv_done) |=> !ctrl_r[ADCC_CTRL_DONE])
        else $error("control write did not clear done");

    // Done only rises after a finished conversion
    AST_DONE_SRC: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ctrl_r[ADCC_CTRL_DONE]) |-> $past(conv_done))
        else $error("done rose without conversion");

    // Low result read leaves done alone
    AST_LOW_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && paddr == ADCC_ADDR_RESL && ctrl_r[ADCC_CTRL_DONE]) |=> ctrl_r[ADCC_CTRL_DONE])
        else $error("low read cleared done");

    // Result registers change only at the end of a conversion
    AST_RES_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !conv_done |=> $stable(result_r))
        else $error("result changed between conversions");

    // Over range saturates to all ones
    AST_SAT_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_done && afe_in.over_range) |=> result_r == ADCC_RES_MAX)
        else $error("no saturation");

    // Under range gives zero
    AST_SAT_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_done && afe_in.under_range && !afe_in.over_range) |=> result_r == ADCC_RES_MIN)
        else $error("no zero result");

    // Converter powers down once the on bit is clear
    AST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_r[ADCC_CTRL_ON]) |=> !afe_out.powered)
        else $error("converter on while off");

    // No conversion can finish while switched off
    AST_OFF_NO_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ADCC_OFF) |-> !conv_done)
        else $error("conversion finished while off");

    // Trial code returns to zero while off
    AST_TRIAL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ADCC_OFF) |=> afe_out.trial == 10'h000)
        else $error("trial code held while off");

    // Setting the on bit powers the converter
    AST_ON_START: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(ctrl_r[ADCC_CTRL_ON]) && !halt_mode) |=> afe_out.powered)
        else $error("converter did not start");

    // Back to back: a new sample follows each finished conversion
    AST_SAMPLE_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_done && ctrl_r[ADCC_CTRL_ON] && !halt_mode) |=> afe_out.sample)
        else $error("no restart after conversion");

    // Selector change aborts the running conversion
    AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_change && state_r == ADCC_CONV) |=> step_r == 4'h0 && !ctrl_r[ADCC_CTRL_DONE])
        else $error("selector change did not abort");

    // Front end never sees a code above the last input
    AST_SEL_CLAMP: assert property (@(posedge pclk) disable iff (!presetn)
        afe_out.select <= ADCC_SEL_MAX)
        else $error("selector out of range");

    // Software fields change only by a control write
    AST_CTRL_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_ctrl |=> $stable(ctrl_r[ADCC_CTRL_RATE:0]))
        else $error("control fields changed without write");

    // Quarter-rate bit changes only by a low register write
    AST_QUARTER_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_low |=> $stable(quarter_r))
        else $error("quarter bit changed without write");

    // Halt disables the converter and drops accuracy
    AST_HALT: assert property (@(posedge pclk) disable iff (!presetn)
        halt_mode |=> state_r == ADCC_OFF && !acc_r)
        else $error("halt did not disable");

    // Stabilisation runs its full count
    AST_STAB_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ADCC_STAB && stab_r != ADCC_STAB_LAST && ctrl_r[ADCC_CTRL_ON] && !halt_mode)
        |=> state_r == ADCC_STAB)
        else $error("stabilisation cut short");

    // Accuracy returns at the end of stabilisation
    AST_ACC_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ADCC_STAB && stab_r == ADCC_STAB_LAST && !halt_mode) |=> results_accurate)
        else $error("accuracy not regained");

    // Wait mode does not stop a running conversion
    AST_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        (wait_mode && state_r == ADCC_CONV && ctrl_r[ADCC_CTRL_ON] && !halt_mode) |=> state_r == ADCC_CONV)
        else $error("wait mode stopped conversion");

    // Read data upper bytes always zero
    AST_RD_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h00_0000)
        else $error("read data upper bytes set");

    // High result read returns result bits nine to two
    AST_RESH_DATA: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == ADCC_ADDR_RESH) |=> prdata[7:0] == $past(result_r[9:2]))
        else $error("high result read wrong");

    // Low result read returns bits one and zero and reserved zeros
    AST_LOW_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == ADCC_ADDR_RESL) |=> prdata[7:4] == 4'h0 && prdata[1:0] == $past(result_r[1:0]))
        else $error("low result read wrong");

    // Steps advance after the sample step and stay in range
    AST_CONV_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && step_r == 4'h0 && !sel_change) |=> step_r == 4'h1 && step_r <= ADCC_CONV_LAST)
        else $error("step did not advance");

    // Cover points for the main scenarios
    COV_DONE: cover property (@(posedge pclk) conv_done);
    COV_ABORT: cover property (@(posedge pclk) sel_change && state_r == ADCC_CONV);
    COV_QUARTER: cover property (@(posedge pclk) conv_done && quarter_r);
    COV_HALT: cover property (@(posedge pclk) halt_mode && state_r == ADCC_CONV);
    COV_EIGHT_BIT: cover property (@(posedge pclk) rd_high && ctrl_r[ADCC_CTRL_DONE]);
endmodule : adcc_top

// [adcc_afe_model.sv]
// Analog front end model: five input levels with range flags, the sampled one held and compared against the trial code.
// Assumes cmp_high means the held level is at or above the trial code.
`timescale 1ns/1ps
module adcc_afe_model (
    // Clock
    input wire logic pclk,
    // Analog levels, ten bits per input, and range flags
    input wire logic [49:0] levels,
    input wire logic [4:0] over,
    input wire logic [4:0] under,
    // Front end link
    input wire adcc_pkg::adcc_afe_out_s afe_out,
    output adcc_pkg::adcc_afe_in_s afe_in
);
    import adcc_pkg::*;
    logic [9:0] held_r;
    logic junk_r = 1'b0;
    // Sample and hold of the selected input; junk toggles so an unpowered front end shows no stable level
    always @(posedge pclk) begin
        junk_r <= ~junk_r;
        if (afe_out.sample) begin
            held_r <= levels[afe_out.select*10 +: 10];
        end
    end
    // Comparator and range detectors
    assign afe_in.cmp_high = afe_out.powered ? (held_r >= afe_out.trial) : junk_r;
    assign afe_in.over_range = afe_out.powered ? over[afe_out.select] : junk_r;
    assign afe_in.under_range = afe_out.powered ? under[afe_out.select] : junk_r;
endmodule : adcc_afe_model

// [tb_adc_conversion_control.sv]
// Testbench for the converter control block: APB register tests over the front end model.
// Assumes zero wait state APB and conversions of eleven conversion-clock ticks.
`timescale 1ns/1ps
module tb_adc_conversion_control;
    import adcc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADCC_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic halt_mode = 1'b0;
    logic wait_mode = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, results_accurate, sample_d;
    logic [49:0] levels = {10'h000, 10'h3FF, 10'h2A5, 10'h001, 10'h15A};
    logic [4:0] over = 5'h08;
    logic [4:0] under = 5'h10;
    logic [9:0] exp;
    logic [23:0] rates [3] = '{24'h2C0824, 24'h0B0064, 24'h160024};
    adcc_afe_in_s afe_in;
    adcc_afe_out_s afe_out;
    int failures = 0;
    int checks = 0;
    int period = 0;
    int cnt = 0;

    adcc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_mode(halt_mode), .wait_mode(wait_mode), .afe_in(afe_in), .afe_out(afe_out),
        .results_accurate(results_accurate));
    adcc_afe_model afe_u (.pclk(pclk), .levels(levels), .over(over), .under(under), .afe_out(afe_out),
        .afe_in(afe_in));

    // Clock
    always #4 pclk = ~pclk;
    // Cycles between successive conversion starts
    always @(posedge pclk) begin
        cnt <= (afe_out.sample && !sample_d) ? 1 : cnt + 1;
        if (afe_out.sample && !sample_d) period <= cnt;
        sample_d <= afe_out.sample;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : check

    // One APB transfer, started right after an edge; read data taken at the completing edge
    task automatic apb(input logic wr, input logic [ADCC_ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Poll the control register until the done flag shows
    task automatic wait_done();
        rd = 32'h0;
        while (rd[7] !== 1'b1) apb(1'b0, ADCC_ADDR_CTRL, 32'h0);
    endtask : wait_done

    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // Watchdog
    initial begin
        #300000;
        failures++;
        tally_and_finish();
    end

    // Test sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADCC_ADDR_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test reset done");
        // Each input in turn, selector changed while converting from input one on
        for (int i = 0; i < 5; i++) begin
            exp = under[i] ? 10'h000 : over[i] ? 10'h3FF : levels[i*10 +: 10];
            wait_mode <= i[0];
            apb(1'b1, ADCC_ADDR_CTRL, 32'(8'h20 + i));
            wait_done();
            check(rd, 32'(8'hA0 + i));
            apb(1'b0, ADCC_ADDR_RESL, 32'h0);
            check(rd, {30'h0, exp[1:0]});
            apb(1'b0, ADCC_ADDR_CTRL, 32'h0);
            check({31'h0, rd[7]}, 32'h1);
            apb(1'b0, ADCC_ADDR_RESH, 32'h0);
            check(rd, {24'h0, exp[9:2]});
            apb(1'b0, ADCC_ADDR_CTRL, 32'h0);
            check({31'h0, rd[7]}, 32'h0);
        end
        wait_done();
        apb(1'b1, ADCC_ADDR_CTRL, 32'h24);
        apb(1'b0, ADCC_ADDR_CTRL, 32'h0);
        check({31'h0, rd[7]}, 32'h0);
        $display("test channels done");
        // Conversion period for quarter, full and half rate
        foreach (rates[k]) begin
            apb(1'b1, ADCC_ADDR_RESL, {24'h0, 8'hF0 | rates[k][15:8]});
            apb(1'b0, ADCC_ADDR_RESL, 32'h0);
            check(rd & 32'hFFFFFFFC, {24'h0, rates[k][15:8]});
            apb(1'b1, ADCC_ADDR_CTRL, {24'h0, rates[k][7:0]});
            repeat (150) @(posedge pclk);
            check(period, {24'h0, rates[k][23:16]});
        end
        $display("test rates done");
        // Converter off: no further samples, no done
        apb(1'b1, ADCC_ADDR_CTRL, 32'h00);
        repeat (100) @(posedge pclk);
        check({31'h0, afe_out.powered}, 32'h0);
        check({31'h0, cnt > 99}, 32'h1);
        apb(1'b0, ADCC_ADDR_CTRL, 32'h0);
        check(rd, 32'h0);
        $display("test off done");
        // Halt and wake-up with stabilisation
        apb(1'b1, ADCC_ADDR_CTRL, 32'h20);
        halt_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        check({30'h0, afe_out.powered, results_accurate}, 32'h0);
        halt_mode <= 1'b0;
        repeat (140) @(posedge pclk);
        check({31'h0, results_accurate}, 32'h1);
        wait_done();
        apb(1'b0, ADCC_ADDR_RESH, 32'h0);
        check(rd, 32'h56);
        $display("test halt done");
        tally_and_finish();
    end
endmodule : tb_adc_conversion_control
